// *** core/adcxr_consts.svh ***
`ifndef ADCXR_CONSTS_SVH
`define ADCXR_CONSTS_SVH
// ==================================================
// frame layout
`define ADCXR_FRAME_BITS   32
`define ADCXR_HEADER       12'h001
`define ADCXR_HDR_BITS     12
// ==================================================
// register addresses
`define ADCXR_ADDR_CFG     4'h1
`define ADCXR_ADDR_OFS1    4'h2
`define ADCXR_ADDR_GAIN1   4'h3
`define ADCXR_ADDR_OFS2    4'hA
`define ADCXR_ADDR_GAIN2   4'hB
`define ADCXR_ADDR_ILV     4'hD
`define ADCXR_ADDR_SKEW    4'hE
// ==================================================
// reset values
`define ADCXR_RST_CFG      16'hB2FF
`define ADCXR_RST_OFS      16'h007F
`define ADCXR_RST_GAIN     16'h807F
`define ADCXR_RST_ILV      16'h3FFF
`define ADCXR_RST_SKEW     16'h07FF
// ==================================================
// field positions
`define ADCXR_CFG_DUTY     12
`define ADCXR_CFG_QUAD     11
`define ADCXR_CFG_SDR      10
`define ADCXR_CFG_SWING    9
`define ADCXR_CFG_EDGE     8
`define ADCXR_OFS_SIGN     7
`define ADCXR_GAIN_LSB     7
`define ADCXR_ILV_ON       15
`define ADCXR_ILV_AUTO     14
`define ADCXR_SKEW_INSEL   15
`define ADCXR_SKEW_TGT     14
`define ADCXR_SKEW_MAG_LSB 11
`endif

// *** core/adcxr_pkg.sv ***
package adcxr_pkg;
	typedef logic [15:0] adcxr_word_t;
	typedef logic [3:0]  adcxr_addr_t;
	typedef enum logic [1:0] {
		ADCXR_IDLE  = 2'b01,
		ADCXR_SHIFT = 2'b10
	} adcxr_state_e;
endpackage : adcxr_pkg

// *** core/adcxr_wr_if.sv ***
// ==================================================
// completed frame handed from the serial receiver to the register bank
interface adcxr_wr_if;
	import adcxr_pkg::*;
	logic        strobe;
	adcxr_addr_t addr;
	adcxr_word_t data;
	modport rx (output strobe, output addr, output data);
	modport bank (input strobe, input addr, input data);
endinterface : adcxr_wr_if

// *** core/adcxr_serial_rx.sv ***
`include "adcxr_consts.svh"
// ==================================================
// three-wire receiver, sampled on clk_sys
module adcxr_serial_rx
	import adcxr_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic ce,
	input  wire logic serial_clk,
	input  wire logic serial_select_n,
	input  wire logic serial_in,
	adcxr_wr_if.rx    wr
);
	// ==================================================
	// synchronisers: stage a feeds only stage b
	logic [2:0] sclk_s, sel_s, din_s;
	logic [2:0] next_sclk_s, next_sel_s, next_din_s;
	logic       sclk_q, sel_q;
	logic       next_sclk_q, next_sel_q;
	logic       sclk_rise;
	// ==================================================
	// frame shifter
	adcxr_state_e state, next_state;
	logic [31:0]  shreg, next_shreg;
	logic [4:0]   cnt, next_cnt;
	logic         next_strobe;
	adcxr_addr_t  next_addr;
	adcxr_word_t  next_data;
	logic [31:0]  full;

	always_comb begin
		next_sclk_s = {sclk_s[1:0], serial_clk};
		next_sel_s  = {sel_s[1:0], serial_select_n};
		next_din_s  = {din_s[1:0], serial_in};
		// a change counts once stages b and c agree
		next_sclk_q = (sclk_s[1] == sclk_s[2]) ? sclk_s[2] : sclk_q;
		next_sel_q  = (sel_s[1] == sel_s[2]) ? sel_s[2] : sel_q;
		sclk_rise   = next_sclk_q && !sclk_q;
		next_state  = state;
		next_shreg  = shreg;
		next_cnt    = cnt;
		next_strobe = 1'b0;
		next_addr   = wr.addr;
		next_data   = wr.data;
		full        = {shreg[30:0], din_s[2]};
		case (state)
			ADCXR_IDLE: begin
				next_cnt = 5'h0;
				if (!next_sel_q) begin
					next_state = ADCXR_SHIFT;
				end
			end
			ADCXR_SHIFT: begin
				// select released mid frame: frame dropped
				if (next_sel_q) begin
					next_state = ADCXR_IDLE;
					next_cnt   = 5'h0;
				end else if (sclk_rise) begin
					next_shreg = full;
					next_cnt   = cnt + 5'h1;
					if (cnt == 5'h1F) begin
						// counter wraps so the 33rd edge opens the next frame
						next_strobe = (full[31:20] == `ADCXR_HEADER);
						next_addr   = full[19:16];
						next_data   = full[15:0];
					end
				end
			end
			default: begin
				next_state = ADCXR_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sclk_s    <= 3'h0;
			sel_s     <= 3'h7;
			din_s     <= 3'h0;
			sclk_q    <= 1'b0;
			sel_q     <= 1'b1;
			state     <= ADCXR_IDLE;
			shreg     <= 32'h0;
			cnt       <= 5'h0;
			wr.strobe <= 1'b0;
			wr.addr   <= 4'h0;
			wr.data   <= 16'h0;
		end else if (ce) begin
			sclk_s    <= next_sclk_s;
			sel_s     <= next_sel_s;
			din_s     <= next_din_s;
			sclk_q    <= next_sclk_q;
			sel_q     <= next_sel_q;
			state     <= next_state;
			shreg     <= next_shreg;
			cnt       <= next_cnt;
			wr.strobe <= next_strobe;
			wr.addr   <= next_addr;
			wr.data   <= next_data;
		end
	end
endmodule : adcxr_serial_rx

// *** core/adcxr_regs.sv ***
`include "adcxr_consts.svh"
module adcxr_regs
	import adcxr_pkg::*;
(
	input  wire logic  clk_sys,
	input  wire logic  rst,
	input  wire logic  ce,
	input  wire logic  extended_mode,
	input  wire logic  serial_clk,
	input  wire logic  serial_select_n,
	input  wire logic  serial_in,
	output logic       duty_stabilizer_on,
	output logic       ddr_clock_quadrature,
	output logic       single_rate_select,
	output logic       output_swing_select,
	output logic       sdr_edge_out,
	output logic [7:0] first_offset_magnitude,
	output logic       first_offset_negative,
	output logic [8:0] first_gain_code,
	output logic [7:0] second_offset_magnitude,
	output logic       second_offset_negative,
	output logic [8:0] second_gain_code,
	output logic       interleave_on,
	output logic       auto_phase_on,
	output logic       interleave_input_select,
	output logic       skew_target_select,
	output logic [2:0] coarse_skew_magnitude
);
	// ==================================================
	// register file
	adcxr_word_t output_configuration, next_output_configuration;
	adcxr_word_t first_channel_offset, next_first_channel_offset;
	adcxr_word_t first_channel_gain, next_first_channel_gain;
	adcxr_word_t second_channel_offset, next_second_channel_offset;
	adcxr_word_t second_channel_gain, next_second_channel_gain;
	adcxr_word_t interleave_control, next_interleave_control;
	adcxr_word_t interleave_coarse_skew, next_interleave_coarse_skew;
	logic        mode_q, next_mode_q;
	adcxr_wr_if  wr ();

	adcxr_serial_rx u_rx (
		.clk_sys         (clk_sys),
		.rst             (rst),
		.ce              (ce),
		.serial_clk      (serial_clk),
		.serial_select_n (serial_select_n),
		.serial_in       (serial_in),
		.wr              (wr)
	);

	function automatic logic hit(input adcxr_addr_t a, input adcxr_addr_t r);
		hit = wr.strobe && mode_q && (a == r);
	endfunction : hit

	always_comb begin
		next_mode_q                 = extended_mode;
		next_output_configuration   = output_configuration;
		next_first_channel_offset   = first_channel_offset;
		next_first_channel_gain     = first_channel_gain;
		next_second_channel_offset  = second_channel_offset;
		next_second_channel_gain    = second_channel_gain;
		next_interleave_control     = interleave_control;
		next_interleave_coarse_skew = interleave_coarse_skew;
		// the serial link is live only in extended mode; reserved addresses fall through
		if (hit(wr.addr, `ADCXR_ADDR_CFG)) next_output_configuration = wr.data;
		if (hit(wr.addr, `ADCXR_ADDR_OFS1)) next_first_channel_offset = wr.data;
		if (hit(wr.addr, `ADCXR_ADDR_GAIN1)) next_first_channel_gain = wr.data;
		if (hit(wr.addr, `ADCXR_ADDR_OFS2)) next_second_channel_offset = wr.data;
		if (hit(wr.addr, `ADCXR_ADDR_GAIN2)) next_second_channel_gain = wr.data;
		if (hit(wr.addr, `ADCXR_ADDR_ILV)) next_interleave_control = wr.data;
		if (hit(wr.addr, `ADCXR_ADDR_SKEW)) next_interleave_coarse_skew = wr.data;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			mode_q                 <= 1'b0;
			output_configuration   <= `ADCXR_RST_CFG;
			first_channel_offset   <= `ADCXR_RST_OFS;
			first_channel_gain     <= `ADCXR_RST_GAIN;
			second_channel_offset  <= `ADCXR_RST_OFS;
			second_channel_gain    <= `ADCXR_RST_GAIN;
			interleave_control     <= `ADCXR_RST_ILV;
			interleave_coarse_skew <= `ADCXR_RST_SKEW;
		end else if (ce) begin
			mode_q                 <= next_mode_q;
			output_configuration   <= next_output_configuration;
			first_channel_offset   <= next_first_channel_offset;
			first_channel_gain     <= next_first_channel_gain;
			second_channel_offset  <= next_second_channel_offset;
			second_channel_gain    <= next_second_channel_gain;
			interleave_control     <= next_interleave_control;
			interleave_coarse_skew <= next_interleave_coarse_skew;
		end
	end

	// ==================================================
	// decoded controls, registered; outside extended mode they show defaults
	adcxr_word_t cfg_e, o1_e, g1_e, o2_e, g2_e, ilv_e, sk_e;
	logic        manual;
	logic        next_duty_stabilizer_on;
	logic        next_ddr_clock_quadrature;
	logic        next_single_rate_select;
	logic        next_output_swing_select;
	logic        next_sdr_edge_out;
	logic [7:0]  next_first_offset_magnitude;
	logic        next_first_offset_negative;
	logic [8:0]  next_first_gain_code;
	logic [7:0]  next_second_offset_magnitude;
	logic        next_second_offset_negative;
	logic [8:0]  next_second_gain_code;
	logic        next_interleave_on;
	logic        next_auto_phase_on;
	logic        next_interleave_input_select;
	logic        next_skew_target_select;
	logic [2:0]  next_coarse_skew_magnitude;

	always_comb begin
		cfg_e  = mode_q ? output_configuration : `ADCXR_RST_CFG;
		o1_e   = mode_q ? first_channel_offset : `ADCXR_RST_OFS;
		g1_e   = mode_q ? first_channel_gain : `ADCXR_RST_GAIN;
		o2_e   = mode_q ? second_channel_offset : `ADCXR_RST_OFS;
		g2_e   = mode_q ? second_channel_gain : `ADCXR_RST_GAIN;
		ilv_e  = mode_q ? interleave_control : `ADCXR_RST_ILV;
		sk_e   = mode_q ? interleave_coarse_skew : `ADCXR_RST_SKEW;
		manual = !ilv_e[`ADCXR_ILV_AUTO];
		next_duty_stabilizer_on      = cfg_e[`ADCXR_CFG_DUTY];
		// quadrature only meaningful in dual rate
		next_ddr_clock_quadrature    = cfg_e[`ADCXR_CFG_QUAD] && !cfg_e[`ADCXR_CFG_SDR];
		next_single_rate_select      = cfg_e[`ADCXR_CFG_SDR];
		next_output_swing_select     = cfg_e[`ADCXR_CFG_SWING];
		next_sdr_edge_out            = cfg_e[`ADCXR_CFG_EDGE];
		next_first_offset_magnitude  = o1_e[15:8];
		next_first_offset_negative   = o1_e[`ADCXR_OFS_SIGN];
		next_first_gain_code         = g1_e[15:`ADCXR_GAIN_LSB];
		next_second_offset_magnitude = o2_e[15:8];
		next_second_offset_negative  = o2_e[`ADCXR_OFS_SIGN];
		next_second_gain_code        = g2_e[15:`ADCXR_GAIN_LSB];
		next_interleave_on           = ilv_e[`ADCXR_ILV_ON];
		next_auto_phase_on           = ilv_e[`ADCXR_ILV_AUTO];
		next_interleave_input_select = sk_e[`ADCXR_SKEW_INSEL];
		next_skew_target_select      = manual && sk_e[`ADCXR_SKEW_TGT];
		next_coarse_skew_magnitude   = manual ? sk_e[13:`ADCXR_SKEW_MAG_LSB] : 3'h0;
	end

	// gain codes feed the analog trim directly, no recalibration handshake
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			duty_stabilizer_on      <= 1'b1;
			ddr_clock_quadrature    <= 1'b0;
			single_rate_select      <= 1'b0;
			output_swing_select     <= 1'b1;
			sdr_edge_out            <= 1'b0;
			first_offset_magnitude  <= 8'h00;
			first_offset_negative   <= 1'b0;
			first_gain_code         <= 9'h100;
			second_offset_magnitude <= 8'h00;
			second_offset_negative  <= 1'b0;
			second_gain_code        <= 9'h100;
			interleave_on           <= 1'b0;
			auto_phase_on           <= 1'b0;
			interleave_input_select <= 1'b0;
			skew_target_select      <= 1'b0;
			coarse_skew_magnitude   <= 3'h0;
		end else if (ce) begin
			duty_stabilizer_on      <= next_duty_stabilizer_on;
			ddr_clock_quadrature    <= next_ddr_clock_quadrature;
			single_rate_select      <= next_single_rate_select;
			output_swing_select     <= next_output_swing_select;
			sdr_edge_out            <= next_sdr_edge_out;
			first_offset_magnitude  <= next_first_offset_magnitude;
			first_offset_negative   <= next_first_offset_negative;
			first_gain_code         <= next_first_gain_code;
			second_offset_magnitude <= next_second_offset_magnitude;
			second_offset_negative  <= next_second_offset_negative;
			second_gain_code        <= next_second_gain_code;
			interleave_on           <= next_interleave_on;
			auto_phase_on           <= next_auto_phase_on;
			interleave_input_select <= next_interleave_input_select;
			skew_target_select      <= next_skew_target_select;
			coarse_skew_magnitude   <= next_coarse_skew_magnitude;
		end
	end
endmodule : adcxr_regs

// *** tb/adcxr_regs_properties.sv ***
// ========
// bank output checker
module adcxr_regs_chk (
	input wire logic       clk_sys,
	input wire logic       rst,
	input wire logic       ce,
	input wire logic       extended_mode,
	input wire logic       serial_select_n,
	input wire logic       duty_stabilizer_on,
	input wire logic       ddr_clock_quadrature,
	input wire logic       single_rate_select,
	input wire logic       output_swing_select,
	input wire logic       sdr_edge_out,
	input wire logic [7:0] first_offset_magnitude,
	input wire logic       first_offset_negative,
	input wire logic [8:0] first_gain_code,
	input wire logic [7:0] second_offset_magnitude,
	input wire logic       second_offset_negative,
	input wire logic [8:0] second_gain_code,
	input wire logic       interleave_on,
	input wire logic       auto_phase_on,
	input wire logic       interleave_input_select,
	input wire logic       skew_target_select,
	input wire logic [2:0] coarse_skew_magnitude
);
	localparam logic [35:0] CHAN_DFLT = {18'h00100, 18'h00100};
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	wire logic [4:0]  cfg_o  = {duty_stabilizer_on, ddr_clock_quadrature, single_rate_select,
		output_swing_select, sdr_edge_out};
	wire logic [35:0] chan_o = {first_offset_magnitude, first_offset_negative, first_gain_code,
		second_offset_magnitude, second_offset_negative, second_gain_code};
	wire logic [6:0]  ilv_o  = {interleave_on, auto_phase_on, interleave_input_select,
		skew_target_select, coarse_skew_magnitude};
	// a write lands a few cycles after its last bit, while select is still low
	sequence write_lands;
		// mode must be high now and three samples back: leaving normal mode changes outputs too
		$changed({cfg_o, chan_o, ilv_o}) && extended_mode && $past(extended_mode, 3);
	endsequence
	sequence link_idle;
		(serial_select_n && extended_mode)[*8];
	endsequence
	AST_RESET_DEFAULTS: assert property ($fell(rst) |->
		cfg_o == 5'h12 && chan_o == CHAN_DFLT && ilv_o == 7'h00)
		else $error("defaults missing after reset");
	// mode pin is registered once, then the outputs: two cycles to show defaults
	AST_NORMAL_CFG: assert property (!extended_mode |-> ##2 cfg_o == 5'h12)
		else $error("config not default in normal mode");
	AST_NORMAL_CHAN: assert property (!extended_mode |-> ##2 chan_o == CHAN_DFLT)
		else $error("channel not default in normal mode");
	AST_NORMAL_ILV: assert property (!extended_mode |-> ##2 ilv_o == 7'h00)
		else $error("interleave not default in normal mode");
	AST_CE_FREEZE: assert property (!ce |=> $stable({cfg_o, chan_o, ilv_o}))
		else $error("outputs moved while clock enable low");
	AST_QUAD_DDR_ONLY: assert property (ddr_clock_quadrature |-> !single_rate_select)
		else $error("quadrature shown in single rate");
	AST_AUTO_SKEW: assert property (auto_phase_on |->
		!skew_target_select && coarse_skew_magnitude == 3'h0)
		else $error("manual skew live under auto phase");
	AST_WRITE_IN_FRAME: assert property (write_lands |-> !$past(serial_select_n, 4))
		else $error("outputs changed outside a frame");
	AST_IDLE_STABLE: assert property (link_idle |-> $stable({cfg_o, chan_o, ilv_o}))
		else $error("outputs changed on idle link");
endmodule : adcxr_regs_chk
bind adcxr_regs adcxr_regs_chk u_chk (.*);

// *** tb/adcxr_host_model.sv ***
// ========
// host end of the three-wire link; its clock stands low between frames
module adcxr_host_model (
	output logic serial_clk,
	output logic serial_select_n,
	output logic serial_in
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		serial_clk      = 1'b0;
		serial_select_n = 1'b1;
		serial_in       = 1'b1;
	end
	// gap stretches the low phase to play a slow host
	task automatic send(input logic [31:0] frame, input int nbits, input logic keep,
			input int gap);
		for (int i = 31; i > 31 - nbits; i--) begin
			serial_select_n = 1'b0;
			serial_in       = frame[i];
			#(80 + gap) serial_clk = 1'b1;
			#80 serial_clk  = 1'b0;
		end
		// no pull on the data pin, so a released line shows the inverse bit
		if (!keep) begin
			serial_select_n = 1'b1;
			serial_in       = ~serial_in;
		end
	endtask : send
endmodule : adcxr_host_model

// *** tb/tb_top.sv ***
`include "adcxr_consts.svh"
// ========
// register bank bench
module tb_top
	import adcxr_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk_sys;
	logic        rst;
	logic        ce;
	logic        extended_mode;
	wire         serial_clk, serial_select_n, serial_in;
	wire         duty_stabilizer_on, ddr_clock_quadrature, single_rate_select;
	wire         output_swing_select, sdr_edge_out, first_offset_negative;
	wire         second_offset_negative, interleave_on, auto_phase_on;
	wire         interleave_input_select, skew_target_select;
	wire [7:0]   first_offset_magnitude, second_offset_magnitude;
	wire [8:0]   first_gain_code, second_gain_code;
	wire [2:0]   coarse_skew_magnitude;
	wire [47:0]  act = {duty_stabilizer_on, ddr_clock_quadrature, single_rate_select,
		output_swing_select, sdr_edge_out, first_offset_magnitude, first_offset_negative,
		first_gain_code, second_offset_magnitude, second_offset_negative, second_gain_code,
		interleave_on, auto_phase_on, interleave_input_select, skew_target_select,
		coarse_skew_magnitude};
	logic [3:0]  adr  [7] = '{4'h1, 4'h2, 4'h3, 4'hA, 4'hB, 4'hD, 4'hE};
	adcxr_word_t rt   [7] = '{`ADCXR_RST_CFG, `ADCXR_RST_OFS, `ADCXR_RST_GAIN,
		`ADCXR_RST_OFS, `ADCXR_RST_GAIN, `ADCXR_RST_ILV, `ADCXR_RST_SKEW};
	adcxr_word_t km   [7] = '{16'h1F00, 16'hFF80, 16'hFF80, 16'hFF80, 16'hFF80, 16'hC000,
		16'hF800};
	adcxr_word_t om   [7] = '{16'hA0FF, 16'h007F, 16'h007F, 16'h007F, 16'h007F, 16'h3FFF,
		16'h07FF};
	adcxr_word_t regs [16];
	adcxr_word_t d;
	logic [47:0] expq [$];
	int          mismatches = 0;
	int          n_tests    = 0;
	int          seed       = 32'h0BCF;
	event        got;
	adcxr_regs       dut (.*);
	adcxr_host_model hm (.*);
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	function automatic logic [47:0] expect_out();
		if (!extended_mode) begin
			return {5'h12, 18'h00100, 18'h00100, 7'h00};
		end
		return {regs[1][12], regs[1][11] & ~regs[1][10], regs[1][10:8], regs[2][15:7],
			regs[3][15:7], regs[10][15:7], regs[11][15:7], regs[13][15:14], regs[14][15],
			regs[14][14] & ~regs[13][14], regs[13][14] ? 3'h0 : regs[14][13:11]};
	endfunction : expect_out
	// outputs settle within a dozen cycles of the last bit
	task automatic note();
		expq.push_back(expect_out());
		repeat (12) @(posedge clk_sys);
		-> got;
	endtask : note
	task automatic wr(input logic [3:0] a, input adcxr_word_t d, input int n = 32,
			input logic keep = 1'b0, input logic [11:0] h = `ADCXR_HEADER);
		hm.send({h, a, d}, n, keep, ($random(seed) & 3) * 40);
		if (n == 32 && h == `ADCXR_HEADER && extended_mode && a inside {adr})
			regs[a] = d;
		note();
	endtask : wr
	task automatic compare_out(input logic [47:0] exp);
		n_tests++;
		if (act !== exp) begin
			mismatches++;
			$display("mismatch at %0t: outputs %h expected %h", $time, act, exp);
		end
	endtask : compare_out
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict
	initial forever begin
		@(got);
		compare_out(expq.pop_front());
	end
	initial begin
		#600000;
		mismatches++;
		$display("mismatch at %0t: watchdog expired", $time);
		give_verdict();
	end
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		extended_mode = 1'b1;
		foreach (adr[i]) regs[adr[i]] = rt[i];
		repeat (5) @(posedge clk_sys);
		#1 rst = 1'b0;
		note();
		$display("test reset done");
		for (int n = 0; n < 3; n++) begin
			foreach (adr[i]) begin
				d = (16'($random(seed)) & km[i]) | om[i];
				// gain kept inside the recommended band
				if (adr[i] == `ADCXR_ADDR_GAIN1 || adr[i] == `ADCXR_ADDR_GAIN2)
					d[15:7] = 9'h0C0 + {1'b0, d[14:7]};
				wr(adr[i], d, 32, i < 6);
			end
		end
		$display("test table done");
		wr(4'h1, 16'hA9FF);
		wr(4'h1, 16'hBFFF);
		wr(4'hD, 16'hFFFF, 32, 1'b1);
		wr(4'hE, 16'hFFFF);
		wr(4'hD, 16'h3FFF);
		$display("test fields done");
		wr(4'hC, 16'h0000, 32, 1'b1);
		wr(4'h0, 16'h0000);
		wr(4'h1, 16'h0000, 32, 1'b0, 12'h003);
		wr(4'h1, 16'h20FF, 20);
		$display("test refusals done");
		// a whole frame sent while frozen must leave no trace
		@(posedge clk_sys);
		#1 ce = 1'b0;
		hm.send({`ADCXR_HEADER, `ADCXR_ADDR_CFG, 16'hA0FF}, 32, 1'b0, 0);
		note();
		#1 ce = 1'b1;
		$display("test freeze done");
		@(posedge clk_sys);
		#1 extended_mode = 1'b0;
		wr(4'h3, 16'h007F);
		@(posedge clk_sys);
		#1 extended_mode = 1'b1;
		note();
		$display("test mode done");
		@(posedge clk_sys);
		#1 rst = 1'b1;
		foreach (adr[i]) regs[adr[i]] = rt[i];
		repeat (5) @(posedge clk_sys);
		#1 rst = 1'b0;
		note();
		$display("test reset again done");
		@(posedge clk_sys);
		give_verdict();
	end
endmodule : tb_top
